// ---- pkg/rtc_pit_consts.svh ----
// constants of the real-time counter and periodic interval timer: offsets, fields, resets,
// timing counts. assumes a 100 MHz system clock and register data 16 bits wide.
// Functional notes
// (RULE1) counter increments per prescaled tick, compares period/match
// (RULE2) counter, period and match are 16 bits
// (RULE3) match flag/event on count after equality
// (RULE4) wrap flag/event on count after period equality
// (RULE5) wrap clears counter to zero
// (RULE6) four timekeeping sources incl. oscillator divided 32
// (RULE7) 15-bit prescaler, division chosen by field
// (RULE8) correction in 1 ppm steps, up to 127
// (RULE9) slow crystal skips counts, fast inserts counts
// (RULE10) interval irq 4..32768 cycles, levels 64..8192
// (RULE11) interval timer enabled independently of counter
// (RULE12) bus clock four times timekeeping clock
// (RULE13) one source select feeds both functions
// (RULE14) software sets source before enabling anything
// (RULE15) counter start order: values, irqs, prescaler, enable
// (RULE16) enable bit one starts, zero stops counter
// (RULE17) interval start order: clock, irq, length, enable
// (RULE18) keeps running and interrupting during sleep
// (RULE19) prescaler stops only when both functions off
// (RULE20) interval output toggles every half interval
// (RULE21) irq asserted while enabled and flag set
`ifndef RTC_PIT_CONSTS_SVH
`define RTC_PIT_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define A_MAIN_CTRL 8'h00
`define A_IRQ_CTRL 8'h01
`define A_IRQ_FLAGS 8'h02
`define A_COUNT 8'h03
`define A_WRAP 8'h04
`define A_MATCH 8'h05
`define A_CALIB 8'h06
`define A_SRC_SEL 8'h07
`define A_PIT_CTRL 8'h08
`define A_PIT_IRQ_CTRL 8'h09
`define A_PIT_FLAGS 8'h0a

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define F_EN 0
`define F_PSC 3
`define F_CORR 7
`define F_OVF 0
`define F_CMP 1
`define F_ERR 0
`define F_ERR_NEG 7
`define F_PIT_EN 0
`define F_PIT_PER 1
`define F_PIT_IE 0
`define F_PIT_FLAG 0

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define WRAP_RST 16'hffff
`define CORR_WINDOW 21'h0f4240
`define OSC_DIV_LAST 5'h1f
`define PIT_CODE_MIN 4'h1
`define PIT_CODE_MAX 4'he
`define PIT_EVT_LSB 5

`endif

// ---- pkg/rtc_pit_pkg.sv ----
// types of the real-time counter and periodic interval timer.
// assumes the constants header is on the include path.
`include "rtc_pit_consts.svh"

package rtc_pit_pkg;

    typedef enum logic [1:0] {SRC_XTAL, SRC_EXT, SRC_OSC, SRC_OSC_DIV} clk_src_t;

    typedef struct packed {
        logic [14:0] presc;
        logic [14:0] prev;
        logic step;
        logic [20:0] acc;
    } presc_state_t;

    typedef struct packed {
        logic [2:0] src_q;
        logic [4:0] odiv;
        clk_src_t src;
        logic cnt_en;
        logic [3:0] psc;
        logic corr_en;
        logic ovf_ie;
        logic cmp_ie;
        logic ovf_f;
        logic cmp_f;
        logic [15:0] cnt;
        logic [15:0] wrap_limit_reg;
        logic [15:0] cmp;
        logic [6:0] err_mag;
        logic err_neg;
        logic pit_en;
        logic [3:0] pit_per;
        logic pit_ie;
        logic pit_f;
        logic pit_seen;
        logic pit_wave;
        logic [15:0] rdata;
        logic irq_rtc;
        logic irq_pit;
        logic ovf_evt;
        logic cmp_evt;
        logic [7:0] pit_evt;
    } rtc_state_t;

endpackage

// ---- design/rtc_prescaler.sv ----
// shared 15-bit prescaler with crystal error correction.
// assumes i_tick is a one-cycle pulse per timekeeping clock period.
`timescale 1ns/1ps
`default_nettype none

module rtc_prescaler import rtc_pit_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_run,
    input wire logic i_corr_en,
    input wire logic [6:0] i_err_mag,
    input wire logic i_err_neg,
    output logic [14:0] o_presc,
    output logic [14:0] o_prev,
    output logic o_step
);

    presc_state_t s;
    presc_state_t n;
    logic [20:0] sum;
    logic fix;

    // ----------------------------------------------------------------
    // counting and correction
    // ----------------------------------------------------------------
    // error is added once per source tick; each window overflow is one fix
    always_comb begin
        n = s;
        n.step = 1'b0;
        n.prev = s.presc;
        sum = s.acc + {14'h0000, i_err_mag}; // RULE8
        fix = i_corr_en && (sum >= `CORR_WINDOW);
        if (i_run && i_tick) begin // RULE19
            n.acc = fix ? sum - `CORR_WINDOW : (i_corr_en ? sum : 21'h000000);
            if (fix && i_err_neg) begin
                n.step = 1'b0; // RULE9
            end else if (fix) begin
                n.presc = s.presc + 15'h0002; // RULE9
                n.step = 1'b1;
            end else begin
                n.presc = s.presc + 15'h0001; // RULE7
                n.step = 1'b1;
            end
        end
    end

    // state register; phase is kept while stopped, so first tick is unknown
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_presc = s.presc;
    assign o_prev = s.prev;
    assign o_step = s.step;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    AST_PRESC_HOLD: assert property (!i_run |=> $stable(o_presc)) // RULE19
        else $error("prescaler moved while both functions off");
    AST_SKIP: assert property (i_run && i_tick && fix && !i_err_neg
        |=> o_presc == $past(o_presc) + 15'h0002 && o_step) // RULE9
        else $error("slow crystal fix did not skip a count");
    AST_INSERT: assert property (i_run && i_tick && fix && i_err_neg
        |=> $stable(o_presc) && !o_step) // RULE9
        else $error("fast crystal fix did not insert a count");

endmodule

`default_nettype wire

// ---- design/rtc_pit.sv ----
// real-time counter and periodic interval timer with register port.
// assumes source clock inputs are sampled by i_clk, which runs far faster than any source.
`timescale 1ns/1ps
`default_nettype none

module rtc_pit import rtc_pit_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_xtal,
    input wire logic i_extclk,
    input wire logic i_osc,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    output logic o_irq_rtc,
    output logic o_irq_pit,
    output logic o_ovf_evt,
    output logic o_cmp_evt,
    output logic [7:0] o_pit_evt,
    output logic o_pit_wave
);

    rtc_state_t s;
    rtc_state_t n;
    logic [2:0] rise;
    logic src_tick;
    logic run;
    logic [14:0] presc;
    logic [14:0] prev;
    logic step;
    logic [15:0] pv;
    logic [15:0] pvp;
    logic ctick;
    logic cmp_hit;
    logic ovf_hit;
    logic pit_ok;
    logic pit_hit;
    logic cnt_wr;
    logic flag_wr;
    logic pit_clr;

    // ----------------------------------------------------------------
    // shared prescaler
    // ----------------------------------------------------------------
    // one prescaler serves both functions so their phases stay locked
    rtc_prescaler u_presc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_tick(src_tick),
        .i_run(run),
        .i_corr_en(s.corr_en),
        .i_err_mag(s.err_mag),
        .i_err_neg(s.err_neg),
        .o_presc(presc),
        .o_prev(prev),
        .o_step(step)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        n = s;
        pv = {1'b0, presc};
        pvp = {1'b0, prev};
        cnt_wr = i_wr && (i_addr == `A_COUNT);
        flag_wr = i_wr && (i_addr == `A_IRQ_FLAGS);
        pit_clr = i_wr && (i_addr == `A_PIT_FLAGS) && i_wdata[`F_PIT_FLAG];

        // source edges; needs i_clk well above the source rate
        n.src_q = {i_osc, i_extclk, i_xtal};
        rise = {i_osc, i_extclk, i_xtal} & ~s.src_q; // RULE12
        if (rise[2]) begin
            n.odiv = s.odiv + 5'h01;
        end

        // one select feeds counter and interval timer alike
        unique case (s.src) // RULE13
            SRC_XTAL: src_tick = rise[0]; // RULE6
            SRC_EXT: src_tick = rise[1];
            SRC_OSC: src_tick = rise[2];
            SRC_OSC_DIV: src_tick = rise[2] && (s.odiv == `OSC_DIV_LAST);
        endcase
        run = s.cnt_en || s.pit_en; // RULE19

        // counter tick when prescaler crosses a multiple of 2^psc
        ctick = step && s.cnt_en && (((presc >> s.psc) != (prev >> s.psc))
            || (presc < prev)); // RULE7
        cmp_hit = ctick && (s.cnt == s.cmp); // RULE3
        ovf_hit = ctick && (s.cnt == s.wrap_limit_reg); // RULE4

        // interval timer fires on a rising edge of the chosen prescaler bit
        pit_ok = (s.pit_per >= `PIT_CODE_MIN) && (s.pit_per <= `PIT_CODE_MAX);
        pit_hit = s.pit_en && pit_ok && step && pv[s.pit_per] && !pvp[s.pit_per]; // RULE10

        // register writes
        if (i_wr) begin
            case (i_addr)
                `A_MAIN_CTRL: begin
                    n.cnt_en = i_wdata[`F_EN]; // RULE16
                    n.psc = i_wdata[`F_PSC +: 4];
                    n.corr_en = i_wdata[`F_CORR];
                end
                `A_IRQ_CTRL: begin
                    n.ovf_ie = i_wdata[`F_OVF];
                    n.cmp_ie = i_wdata[`F_CMP];
                end
                `A_COUNT: n.cnt = i_wdata;
                `A_WRAP: n.wrap_limit_reg = i_wdata; // RULE2
                `A_MATCH: n.cmp = i_wdata;
                `A_CALIB: begin
                    n.err_mag = i_wdata[`F_ERR +: 7];
                    n.err_neg = i_wdata[`F_ERR_NEG];
                end
                `A_SRC_SEL: n.src = clk_src_t'(i_wdata[1:0]);
                `A_PIT_CTRL: begin
                    n.pit_en = i_wdata[`F_PIT_EN]; // RULE11
                    n.pit_per = i_wdata[`F_PIT_PER +: 4];
                end
                `A_PIT_IRQ_CTRL: n.pit_ie = i_wdata[`F_PIT_IE];
                default: begin
                end
            endcase
        end

        // write one to clear; clears first so a same-cycle hit survives
        if (flag_wr && i_wdata[`F_OVF]) begin
            n.ovf_f = 1'b0;
        end
        if (flag_wr && i_wdata[`F_CMP]) begin
            n.cmp_f = 1'b0;
        end
        if (pit_clr) begin
            n.pit_f = 1'b0;
        end

        // counting, wrap and flag setting
        if (ctick) begin
            n.cnt = ovf_hit ? 16'h0000 : s.cnt + 16'h0001; // RULE1 RULE5
        end
        if (ovf_hit) begin
            n.ovf_f = 1'b1; // RULE4
        end
        if (cmp_hit) begin
            n.cmp_f = 1'b1; // RULE3
        end
        if (pit_hit) begin
            n.pit_f = 1'b1; // RULE10
        end
        n.ovf_evt = ovf_hit;
        n.cmp_evt = cmp_hit;

        // square wave at the interval, shown after the first interrupt
        n.pit_seen = s.pit_en && pit_ok && (s.pit_seen || pit_hit);
        n.pit_wave = n.pit_seen && pv[s.pit_per]; // RULE20
        n.pit_evt = presc[`PIT_EVT_LSB +: 8]; // RULE10

        // request lines; no clock gating, so they work in any sleep state
        n.irq_rtc = (n.ovf_f && n.ovf_ie) || (n.cmp_f && n.cmp_ie); // RULE21 RULE18
        n.irq_pit = n.pit_f && n.pit_ie; // RULE21

        // read data stand in the cycle after the strobe only
        n.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                `A_MAIN_CTRL: begin
                    n.rdata[`F_EN] = s.cnt_en;
                    n.rdata[`F_PSC +: 4] = s.psc;
                    n.rdata[`F_CORR] = s.corr_en;
                end
                `A_IRQ_CTRL: begin
                    n.rdata[`F_OVF] = s.ovf_ie;
                    n.rdata[`F_CMP] = s.cmp_ie;
                end
                `A_IRQ_FLAGS: begin
                    n.rdata[`F_OVF] = s.ovf_f;
                    n.rdata[`F_CMP] = s.cmp_f;
                end
                `A_COUNT: n.rdata = s.cnt;
                `A_WRAP: n.rdata = s.wrap_limit_reg;
                `A_MATCH: n.rdata = s.cmp;
                `A_CALIB: begin
                    n.rdata[`F_ERR +: 7] = s.err_mag;
                    n.rdata[`F_ERR_NEG] = s.err_neg;
                end
                `A_SRC_SEL: n.rdata[1:0] = s.src;
                `A_PIT_CTRL: begin
                    n.rdata[`F_PIT_EN] = s.pit_en;
                    n.rdata[`F_PIT_PER +: 4] = s.pit_per;
                end
                `A_PIT_IRQ_CTRL: n.rdata[`F_PIT_IE] = s.pit_ie;
                `A_PIT_FLAGS: n.rdata[`F_PIT_FLAG] = s.pit_f;
                default: n.rdata = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '0;
            s.wrap_limit_reg <= `WRAP_RST;
        end else begin
            s <= n;
        end
    end

    // outputs straight from the state flops
    assign o_rdata = s.rdata;
    assign o_irq_rtc = s.irq_rtc;
    assign o_irq_pit = s.irq_pit;
    assign o_ovf_evt = s.ovf_evt;
    assign o_cmp_evt = s.cmp_evt;
    assign o_pit_evt = s.pit_evt;
    assign o_pit_wave = s.pit_wave;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    AST_INC: assert property (ctick && !ovf_hit && !cnt_wr |=> // RULE1
        s.cnt == $past(s.cnt) + 16'h0001)
        else $error("counter did not step on a tick");
    AST_CMP: assert property (cmp_hit |=> s.cmp_f && o_cmp_evt ##1 !o_cmp_evt) // RULE3
        else $error("match hit lost or event not one cycle");
    AST_OVF: assert property (ovf_hit |=> s.ovf_f && o_ovf_evt) // RULE4
        else $error("wrap hit lost");
    AST_WRAP: assert property (ovf_hit && !cnt_wr |=> s.cnt == 16'h0000) // RULE5
        else $error("counter not cleared on wrap");
    AST_STOP: assert property (!s.cnt_en && !cnt_wr |=> $stable(s.cnt)) // RULE16
        else $error("counter moved while disabled");
    AST_IRQ: assert property (o_irq_rtc ==
        ((s.ovf_f && s.ovf_ie) || (s.cmp_f && s.cmp_ie))) // RULE21
        else $error("counter request disagrees with flags and enables");
    AST_PIT_HOLD: assert property (s.pit_f && !pit_clr |=> s.pit_f && // RULE21
        (o_irq_pit == s.pit_ie))
        else $error("interval flag dropped without a clear");
    AST_PIT_OFF: assert property (!s.pit_en && !s.pit_f && !pit_clr |=> !s.pit_f) // RULE11
        else $error("interval flag set while timer disabled");
    AST_PIT_GAP: assert property (pit_hit |=> !pit_hit [*3]) // RULE10
        else $error("interval hits closer than minimum spacing");

    COV_WRAP: cover property (ovf_hit ##1 o_irq_rtc);
    COV_MATCH: cover property (cmp_hit);
    COV_PIT: cover property (pit_hit ##1 o_irq_pit);
    COV_WAVE: cover property ($rose(o_pit_wave));

endmodule

`default_nettype wire

// ---- verif/rtc_pit_tb.sv ----
// ----------------------------------------------------------------
// testbench of the real-time counter and interval timer
// ----------------------------------------------------------------
// covers register port, counting, wrap, match, prescaler, source select and interval timer.
// assumes the package and constants header are compiled first and i_clk runs at 100 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_pit_consts.svh"

module rtc_pit_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [2:0] src = 3'h0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic irq_rtc, irq_pit, ovf_evt, cmp_evt, pit_wave;
    logic [7:0] pit_evt;
    logic evt_q = 1'b0;
    logic wave_q = 1'b0;
    int errors = 0;
    int comparisons = 0;
    int ovf_n = 0;
    int cmp_n = 0;
    int evt_rise = 0;
    int wave_rise = 0;

    always #5 i_clk = ~i_clk;

    rtc_pit uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_xtal(src[0]), .i_extclk(src[1]), .i_osc(src[2]),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_irq_rtc(irq_rtc), .o_irq_pit(irq_pit), .o_ovf_evt(ovf_evt), .o_cmp_evt(cmp_evt),
        .o_pit_evt(pit_evt), .o_pit_wave(pit_wave)
    );

    // ----------------------------------------------------------------
    // monitors: event pulses last one cycle, so they are counted at every edge
    // ----------------------------------------------------------------
    always @(posedge i_clk) begin
        if (ovf_evt === 1'b1) ovf_n++;
        if (cmp_evt === 1'b1) cmp_n++;
        if (pit_evt[0] === 1'b1 && evt_q === 1'b0) evt_rise++;
        if (pit_wave === 1'b1 && wave_q === 1'b0) wave_rise++;
        evt_q <= pit_evt[0];
        wave_q <= pit_wave;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic reg_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    // source high for three bus cycles and low for four, a source period of seven bus cycles
    task automatic ticks(input int s, input int n);
        repeat (n) begin
            @(posedge i_clk);
            src[s] <= 1'b1;
            repeat (3) @(posedge i_clk);
            src[s] <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
        repeat (4) @(posedge i_clk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_regs;
        reg_chk("wrap reset", `A_WRAP, 16'hffff);
        reg_chk("count reset", `A_COUNT, 16'h0000);
        reg_wr(`A_MATCH, 16'hbeef);
        reg_chk("match rw", `A_MATCH, 16'hbeef);
        reg_wr(`A_CALIB, 16'hffff);
        reg_chk("calib width", `A_CALIB, 16'h00ff);
        reg_wr(8'h20, 16'h5a5a);
        reg_chk("unmapped", 8'h20, 16'h0000);
        $display("test_regs done");
    endtask

    task automatic test_wrap;
        reg_wr(`A_SRC_SEL, 16'h0000);
        reg_wr(`A_WRAP, 16'h0003);
        reg_wr(`A_MATCH, 16'h0001);
        reg_wr(`A_COUNT, 16'h0000);
        reg_wr(`A_IRQ_CTRL, 16'h0003);
        reg_wr(`A_MAIN_CTRL, 16'h0001);
        ovf_n = 0;
        cmp_n = 0;
        ticks(0, 1);
        reg_chk("flags at match", `A_IRQ_FLAGS, 16'h0000);
        ticks(0, 1);
        reg_chk("count", `A_COUNT, 16'h0002);
        reg_chk("flags after match", `A_IRQ_FLAGS, 16'h0002);
        chk("cmp events", 16'h0001, 16'(cmp_n));
        chk("rtc irq", 16'h0001, {15'h0, irq_rtc});
        ticks(0, 2);
        reg_chk("count wrapped", `A_COUNT, 16'h0000);
        reg_chk("flags after wrap", `A_IRQ_FLAGS, 16'h0003);
        chk("ovf events", 16'h0001, 16'(ovf_n));
        reg_wr(`A_IRQ_FLAGS, 16'h0003);
        reg_chk("flags cleared", `A_IRQ_FLAGS, 16'h0000);
        chk("rtc irq cleared", 16'h0000, {15'h0, irq_rtc});
        reg_wr(`A_MAIN_CTRL, 16'h0000);
        ticks(0, 3);
        reg_chk("count stopped", `A_COUNT, 16'h0000);
        $display("test_wrap done");
    endtask

    // divide by four: eight source cycles always cross exactly two multiples of four
    task automatic test_psc;
        reg_wr(`A_WRAP, 16'hffff);
        reg_wr(`A_COUNT, 16'h0000);
        reg_wr(`A_MAIN_CTRL, 16'h0011);
        ticks(0, 8);
        reg_chk("count div4", `A_COUNT, 16'h0002);
        $display("test_psc done");
    endtask

    task automatic test_src;
        reg_wr(`A_MAIN_CTRL, 16'h0001);
        for (int s = 0; s < 3; s++) begin
            reg_wr(`A_SRC_SEL, 16'(s));
            reg_wr(`A_COUNT, 16'h0000);
            ticks((s + 1) % 3, 3);
            reg_chk("count other pin", `A_COUNT, 16'h0000);
            ticks(s, 3);
            reg_chk("count own pin", `A_COUNT, 16'h0003);
        end
        reg_wr(`A_SRC_SEL, 16'h0003);
        reg_wr(`A_COUNT, 16'h0000);
        ticks(2, 64);
        reg_chk("count osc div32", `A_COUNT, 16'h0002);
        reg_wr(`A_MAIN_CTRL, 16'h0000);
        $display("test_src done");
    endtask

    task automatic test_pit;
        reg_wr(`A_SRC_SEL, 16'h0000);
        reg_wr(`A_COUNT, 16'h0005);
        reg_wr(`A_PIT_IRQ_CTRL, 16'h0001);
        reg_wr(`A_PIT_CTRL, 16'h0003);
        ticks(0, 4);
        reg_chk("pit flag", `A_PIT_FLAGS, 16'h0001);
        chk("pit irq", 16'h0001, {15'h0, irq_pit});
        reg_chk("count idle", `A_COUNT, 16'h0005);
        wave_rise = 0;
        ticks(0, 16);
        chk("wave rises", 16'h0004, 16'(wave_rise));
        evt_rise = 0;
        ticks(0, 128);
        chk("div64 rises", 16'h0002, 16'(evt_rise));
        reg_wr(`A_PIT_FLAGS, 16'h0001);
        reg_chk("pit flag cleared", `A_PIT_FLAGS, 16'h0000);
        chk("pit irq cleared", 16'h0000, {15'h0, irq_pit});
        $display("test_pit done");
    endtask

    // fast crystal, 127 ppm: the 7875th source tick crosses one million and is swallowed,
    // so at divide-by-one the counter ends one short; source kept at exactly 4x bus ratio
    task automatic test_corr;
        reg_wr(`A_SRC_SEL, 16'h0000);
        reg_wr(`A_COUNT, 16'h0000);
        reg_wr(`A_CALIB, 16'h00ff);
        reg_wr(`A_MAIN_CTRL, 16'h0081);
        repeat (7875) begin
            @(posedge i_clk);
            src[0] <= 1'b1;
            repeat (2) @(posedge i_clk);
            src[0] <= 1'b0;
            @(posedge i_clk);
        end
        repeat (4) @(posedge i_clk);
        reg_chk("count inserted", `A_COUNT, 16'h1ec2);
        reg_wr(`A_MAIN_CTRL, 16'h0000);
        $display("test_corr done");
    endtask

    // ----------------------------------------------------------------
    // verdict and main sequence
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // the whole run needs about 35000 cycles, most in the correction test
    initial begin
        #600000;
        errors++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        test_regs();
        test_wrap();
        test_psc();
        test_src();
        test_pit();
        test_corr();
        test_done();
    end
endmodule

`default_nettype wire
